// ===== hw/eccp_pkg.sv
package eccp_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DUTY   = 8'h01;
    localparam logic [7:0] ADDR_STAT   = 8'h02;
    localparam logic [7:0] ADDR_MASK   = 8'h03;
    localparam logic [7:0] ADDR_CAP_LO = 8'h04;
    localparam logic [7:0] ADDR_CAP_HI = 8'h05;

    // Values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;

    // Position of the unit flag in status and mask
    localparam int unsigned FLAG_BIT = 0;

    // Prescaler terminal counts for every 4th and 16th edge
    localparam logic [3:0] PRESC_4  = 4'h3;
    localparam logic [3:0] PRESC_16 = 4'hF;

    // Deadband time and its cycle count at 200 MHz
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned DEAD_TIME_NS  = 50;
    localparam int unsigned DEAD_CYC =
        (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Unit mode codes
    typedef enum logic [3:0] {
        MODE_OFF      = 4'h0,
        MODE_RSV1     = 4'h1,
        MODE_CMP_TGL  = 4'h2,
        MODE_RSV3     = 4'h3,
        MODE_CAP_FALL = 4'h4,
        MODE_CAP_RISE = 4'h5,
        MODE_CAP_R4   = 4'h6,
        MODE_CAP_R16  = 4'h7,
        MODE_CMP_SET  = 4'h8,
        MODE_CMP_CLR  = 4'h9,
        MODE_CMP_FLAG = 4'hA,
        MODE_CMP_SPEC = 4'hB,
        MODE_PWM_HH   = 4'hC,
        MODE_PWM_LH   = 4'hD,
        MODE_PWM_HL   = 4'hE,
        MODE_PWM_LL   = 4'hF
    } mode_t;

    // PWM output steering
    typedef enum logic [1:0] {
        STEER_SINGLE = 2'b00,
        STEER_FWD    = 2'b01,
        STEER_HALF   = 2'b10,
        STEER_REV    = 2'b11
    } steer_t;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        steer_t      pwm_output_config;
        logic [1:0]  duty_low_bits;
        mode_t       unit_mode_select;
    } ctrl_t;

    // One bit for each of the four output pins
    typedef struct packed {
        logic d;
        logic c;
        logic b;
        logic a;
    } pins_t;

    // True for the four PWM codes
    function automatic logic is_pwm(input mode_t m);
        return m[3:2] == 2'b11;
    endfunction

    // True for the compare codes
    function automatic logic is_cmp(input mode_t m);
        return (m == MODE_CMP_TGL) || (m[3:2] == 2'b10);
    endfunction

    // Pins that are active low in a PWM code
    function automatic pins_t act_low(input mode_t m);
        pins_t p;
        p.a = m[0];
        p.c = m[0];
        p.b = m[1];
        p.d = m[1];
        return p;
    endfunction

endpackage

// ===== hw/dead_band.sv
`timescale 1ns/1ps
`default_nettype none
// Complementary pair with both sides off for DEAD_CYC cycles at each edge
module dead_band import eccp_pkg::*; #(
    parameter int unsigned DEAD_N = DEAD_CYC
) (
    input  wire logic ref_clk_i,  // Core clock
    input  wire logic rst_b_i,    // Async reset, active low
    input  wire logic clr_i,      // Hold both sides off
    input  wire logic pwm_i,      // Raw modulated waveform
    output logic      hi_o,       // Side following the waveform
    output logic      lo_o        // Complementary side
);
    localparam int unsigned CW = $clog2(DEAD_N + 1);

    // Refuse a deadband that the counter cannot serve
    if (DEAD_N < 1) begin : g_bad_dead
        $error("dead_band needs DEAD_N of at least 1");
    end

    logic [CW-1:0] cnt_ff;  // Remaining dead cycles
    logic          lvl_ff;  // Waveform level last seen

    // Any edge turns both sides off, then the new side waits its dead time
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_ff <= '0;
            lvl_ff <= 1'b0;
            hi_o   <= 1'b0;
            lo_o   <= 1'b0;
        end else if (clr_i) begin
            cnt_ff <= CW'(DEAD_N - 1);
            lvl_ff <= pwm_i;
            hi_o   <= 1'b0;
            lo_o   <= 1'b0;
        end else if (pwm_i != lvl_ff) begin
            cnt_ff <= CW'(DEAD_N - 1);
            lvl_ff <= pwm_i;
            hi_o   <= 1'b0;
            lo_o   <= 1'b0;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end else begin
            hi_o <= lvl_ff;
            lo_o <= ~lvl_ff;
        end
    end

endmodule
`default_nettype wire

// ===== hw/eccp_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module eccp_mode_ctrl import eccp_pkg::*; #(
    parameter int unsigned TMR_W  = 16,       // Timer width
    parameter int unsigned DEAD_N = DEAD_CYC  // Deadband cycles
) (
    input  wire logic             ref_clk_i,   // Core clock, 200 MHz
    input  wire logic             rst_b_i,     // Async reset, active low
    input  wire logic [7:0]       addr_i,      // Register address
    input  wire logic [7:0]       wdata_i,     // Write data
    input  wire logic             wr_i,        // Write strobe
    input  wire logic             rd_i,        // Read strobe
    output logic      [7:0]       rdata_o,     // Read data, next cycle
    input  wire logic [TMR_W-1:0] timer_i,     // Running timer value
    input  wire logic             match_i,     // Compare match pulse
    input  wire logic             pwm_raw_i,   // Raw PWM waveform
    input  wire logic             adc_en_i,    // Converter enabled
    input  wire logic             cap_pin_i,   // Capture pin, async
    output pins_t                 pin_o,       // Pin output levels
    output pins_t                 pin_oe_b_o,  // Pin enables, low drives
    output logic      [9:0]       duty_o,      // Ten-bit PWM duty
    output logic                  tmr_rst_o,   // Timer reset pulse
    output logic                  adc_go_o,    // Conversion start pulse
    output logic                  irq_o        // Interrupt level
);

    // Refuse timer widths that the two capture bytes cannot carry
    if (TMR_W < 9 || TMR_W > 16) begin : g_bad_tmr
        $error("TMR_W must be 9 to 16");
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    ////////////////////////////////////////////////////////////////////

    ctrl_t             ctrl_ff;   // Control register
    logic [7:0]        duty_ff;   // Duty high byte
    logic              flag_ff;   // Sticky unit flag
    logic              mask_ff;   // Flag mask
    logic [TMR_W-1:0]  cap_ff;    // Captured timer value
    logic              cmp_ff;    // Compare output latch
    logic              sync1_ff;  // Pin synchroniser, first stage
    logic              sync2_ff;  // Pin synchroniser, second stage
    logic              sync3_ff;  // Delayed copy for edges
    logic [3:0]        presc_ff;  // Rising edge prescaler

    mode_t  mode;      // Current mode field
    steer_t steer;     // Current steering field
    logic   off;       // Unit held idle
    logic   wr_ctrl;   // Control write
    logic   wr_stat;   // Status write
    logic   rise;      // Rising pin edge
    logic   fall;      // Falling pin edge
    logic   cmp_ev;    // Match in a compare mode
    logic   cap_ev;    // Capture taken
    logic   nxt_flag;  // Next unit flag
    logic   db_hi;     // Deadband side A
    logic   db_lo;     // Deadband side B

    assign mode    = ctrl_ff.unit_mode_select;
    assign steer   = ctrl_ff.pwm_output_config;
    assign off     = (mode == MODE_OFF);
    assign wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
    assign wr_stat = wr_i && (addr_i == ADDR_STAT);
    assign rise    = sync2_ff && !sync3_ff;
    assign fall    = !sync2_ff && sync3_ff;
    assign cmp_ev  = match_i && is_cmp(mode);

    // Software writes to control, duty and mask
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_ff <= ctrl_t'(CTRL_RST);
            duty_ff <= DUTY_RST;
            mask_ff <= MASK_RST[FLAG_BIT];
        end else if (wr_i) begin
            if (addr_i == ADDR_CTRL) begin
                ctrl_ff <= ctrl_t'(wdata_i);
            end
            if (addr_i == ADDR_DUTY) begin
                duty_ff <= wdata_i;
            end
            if (addr_i == ADDR_MASK) begin
                mask_ff <= wdata_i[FLAG_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Capture path
    ////////////////////////////////////////////////////////////////////

    // Two-stage synchroniser plus one stage for edge detection
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= cap_pin_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Decide which edge captures in the current mode
    always_comb begin
        cap_ev = 1'b0;
        unique case (mode)
            MODE_CAP_FALL: cap_ev = fall;
            MODE_CAP_RISE: cap_ev = rise;
            MODE_CAP_R4:   cap_ev = rise && (presc_ff[1:0] == PRESC_4[1:0]);
            MODE_CAP_R16:  cap_ev = rise && (presc_ff == PRESC_16);
            MODE_OFF, MODE_RSV1, MODE_RSV3, MODE_CMP_TGL,
            MODE_CMP_SET, MODE_CMP_CLR, MODE_CMP_FLAG,
            MODE_CMP_SPEC, MODE_PWM_HH, MODE_PWM_LH,
            MODE_PWM_HL, MODE_PWM_LL: cap_ev = 1'b0;
        endcase
    end

    // Count rising edges only while a prescaled mode is chosen
    // Switching to another mode restarts the count, so no stale edges
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            presc_ff <= 4'h0;
        end else if (mode != MODE_CAP_R4 && mode != MODE_CAP_R16) begin
            presc_ff <= 4'h0;
        end else if (wr_ctrl && (wdata_i[3:0] != mode)) begin
            presc_ff <= 4'h0;
        end else if (rise) begin
            presc_ff <= presc_ff + 4'h1;
        end
    end

    // Latch the timer on a capture event; idle clears it
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cap_ff <= '0;
        end else if (off) begin
            cap_ff <= '0;
        end else if (cap_ev) begin
            cap_ff <= timer_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Compare path
    ////////////////////////////////////////////////////////////////////

    // Compare output latch acts on a match by mode
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmp_ff <= 1'b0;
        end else if (off) begin
            cmp_ff <= 1'b0;
        end else if (match_i) begin
            unique case (mode)
                MODE_CMP_TGL: cmp_ff <= ~cmp_ff;
                MODE_CMP_SET: cmp_ff <= 1'b1;
                MODE_CMP_CLR: cmp_ff <= 1'b0;
                MODE_OFF, MODE_RSV1, MODE_RSV3, MODE_CAP_FALL,
                MODE_CAP_RISE, MODE_CAP_R4, MODE_CAP_R16,
                MODE_CMP_FLAG, MODE_CMP_SPEC, MODE_PWM_HH,
                MODE_PWM_LH, MODE_PWM_HL,
                MODE_PWM_LL: cmp_ff <= cmp_ff;
            endcase
        end
    end

    // Special event pulses for timer reset and conversion start
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tmr_rst_o <= 1'b0;
            adc_go_o  <= 1'b0;
        end else begin
            tmr_rst_o <= match_i && (mode == MODE_CMP_SPEC);
            adc_go_o  <= match_i && (mode == MODE_CMP_SPEC)
                         && adc_en_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt
    ////////////////////////////////////////////////////////////////////

    // A new event wins over a write-one clear in the same cycle
    assign nxt_flag = cmp_ev || cap_ev ||
                      (flag_ff && !(wr_stat && wdata_i[FLAG_BIT]));

    // Sticky flag and its masked interrupt level
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_ff <= 1'b0;
            irq_o   <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
            irq_o   <= nxt_flag && mask_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port
    ////////////////////////////////////////////////////////////////////

    // Read data stand for one cycle; unmapped reads return zero
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (!rd_i) begin
            rdata_o <= 8'h00;
        end else begin
            unique case (addr_i)
                ADDR_CTRL:   rdata_o <= ctrl_ff;
                ADDR_DUTY:   rdata_o <= duty_ff;
                ADDR_STAT:   rdata_o <= {7'h00, flag_ff};
                ADDR_MASK:   rdata_o <= {7'h00, mask_ff};
                ADDR_CAP_LO: rdata_o <= cap_ff[7:0];
                ADDR_CAP_HI: rdata_o <= 8'(cap_ff[TMR_W-1:8]);
                default:     rdata_o <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Duty cycle and pin steering
    ////////////////////////////////////////////////////////////////////

    // Full duty only in PWM; duty_o is zero in every other mode
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            duty_o <= 10'h000;
        end else if (is_pwm(mode)) begin
            duty_o <= {duty_ff, ctrl_ff.duty_low_bits};
        end else begin
            duty_o <= 10'h000;
        end
    end

    // Complementary pair for the half bridge
    dead_band #(
        .DEAD_N (DEAD_N)
    ) u_dead (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .clr_i     (!(is_pwm(mode) && steer == STEER_HALF)),
        .pwm_i     (pwm_raw_i),
        .hi_o      (db_hi),
        .lo_o      (db_lo)
    );

    pins_t lvl;  // Active-high pin levels
    pins_t oeb;  // Enables, low drives

    // Steer the waveform onto the pins by mode and configuration
    always_comb begin
        lvl = '0;
        oeb = '1;
        if (is_pwm(mode)) begin
            unique case (steer)
                STEER_SINGLE: begin
                    lvl.a = pwm_raw_i;
                    oeb.a = 1'b0;
                end
                STEER_FWD: begin
                    lvl.d = pwm_raw_i;
                    lvl.a = 1'b1;
                    oeb   = '0;
                end
                STEER_HALF: begin
                    lvl.a = db_hi;
                    lvl.b = db_lo;
                    oeb.a = 1'b0;
                    oeb.b = 1'b0;
                end
                STEER_REV: begin
                    lvl.b = pwm_raw_i;
                    lvl.c = 1'b1;
                    oeb   = '0;
                end
            endcase
        end else if (is_cmp(mode)) begin
            lvl.a = cmp_ff;
            oeb.a = 1'b0;
        end
    end

    // Register pins; polarity applies only to PWM pins being driven
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_o      <= '0;
            pin_oe_b_o <= '1;
        end else begin
            pin_oe_b_o <= oeb;
            if (is_pwm(mode)) begin
                pin_o <= lvl ^ (act_low(mode) & ~oeb);
            end else begin
                pin_o <= lvl;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    chk_cap_release: assert property (
        !is_pwm(mode) |=> pin_oe_b_o.b && pin_oe_b_o.c && pin_oe_b_o.d)
        else $error("Port pins not released outside PWM");

    chk_single_out: assert property (
        is_pwm(mode) && steer == STEER_SINGLE |=>
        !pin_oe_b_o.a && pin_oe_b_o[3:1] == 3'h7 &&
        pin_o.a == ($past(pwm_raw_i) ^ $past(mode[0])))
        else $error("Single output steering wrong");

    chk_fwd_bridge: assert property (
        mode == MODE_PWM_HH && steer == STEER_FWD |=>
        pin_oe_b_o == 4'h0 && pin_o.a && !pin_o.b && !pin_o.c &&
        pin_o.d == $past(pwm_raw_i))
        else $error("Forward bridge levels wrong");

    chk_half_pair: assert property (
        is_pwm(mode) && steer == STEER_HALF |=>
        pin_oe_b_o == 4'hC && !(db_hi && db_lo))
        else $error("Half bridge pair wrong");

    chk_rev_bridge: assert property (
        mode == MODE_PWM_HH && steer == STEER_REV |=>
        pin_oe_b_o == 4'h0 && !pin_o.a && pin_o.c && !pin_o.d &&
        pin_o.b == $past(pwm_raw_i))
        else $error("Reverse bridge levels wrong");

    chk_duty_form: assert property (
        is_pwm(mode) |=> duty_o == {$past(duty_ff), $past(ctrl_ff[5:4])})
        else $error("Duty cycle not formed");

    chk_off_idle: assert property (
        off [*2] |=> cap_ff == '0 && !cmp_ff && pin_oe_b_o == 4'hF)
        else $error("Unit not idle when off");

    chk_toggle_flag: assert property (
        mode == MODE_CMP_TGL && match_i |=>
        cmp_ff != $past(cmp_ff) && flag_ff)
        else $error("Toggle on match missing");

    chk_cap_fall: assert property (
        mode == MODE_CAP_FALL && fall |=>
        cap_ff == $past(timer_i) && flag_ff)
        else $error("Falling edge capture missing");

    chk_special_evt: assert property (
        mode == MODE_CMP_SPEC && match_i |=>
        tmr_rst_o && adc_go_o == $past(adc_en_i) && flag_ff)
        else $error("Special event pulses wrong");

    cov_toggle:    cover property (mode == MODE_CMP_TGL && match_i);
    cov_capture:   cover property (cap_ev ##1 irq_o);
    cov_half:      cover property (is_pwm(mode) && steer == STEER_HALF
                                   && db_hi ##[1:40] db_lo);
    cov_clear_set: cover property (wr_stat && wdata_i[0] && cmp_ev);

endmodule
`default_nettype wire

// ===== bench/bridge_drv_model.sv
`timescale 1ns/1ps
`default_nettype none
// Bridge driver seen from the pins: released pins float up
module bridge_drv_model import eccp_pkg::*; (
    input  wire logic  ref_clk_i,   // Core clock
    input  wire logic  rst_b_i,     // Async reset, active low
    input  wire pins_t pin_i,       // Levels from the block
    input  wire pins_t pin_oe_b_i,  // Low where the block drives
    output pins_t      pad_o,       // Pad levels seen by the bridge
    output logic       shoot_o      // Sticky: both A/B legs on
);
    // Pull-ups win on every released pin
    assign pad_o = pin_i | pin_oe_b_i;

    // Both legs on at once would short the supply rail
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shoot_o <= 1'b0;
        end else if (!pin_oe_b_i.a && !pin_oe_b_i.b &&
                     pin_i.a && pin_i.b) begin
            shoot_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== bench/enhanced_ccp_mode_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module enhanced_ccp_mode_control_tb_top;
    import eccp_pkg::*;
    localparam int unsigned DN = 2;  // Short deadband for the run
    logic        ref_clk_i = 1'b0;
    logic        rst_b_i   = 1'b0;
    logic [7:0]  addr_i    = 8'h00;
    logic [7:0]  wdata_i   = 8'h00;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic        match_i   = 1'b0;
    logic        pwm_raw_i = 1'b0;
    logic        adc_en_i  = 1'b0;
    logic        cap_pin_i = 1'b1;
    logic [15:0] timer_i   = 16'h0000;
    logic [7:0]  rdata_o;
    logic [9:0]  duty_o;
    logic        tmr_rst_o, adc_go_o, irq_o, shoot;
    pins_t       pin_o, pin_oe_b_o, pad;
    int          miscompares = 0;
    int          n_checks    = 0;
    int          cyc         = 0;
    logic [31:0] rnd         = 32'h0001_0711;  // Seed 67345
    logic [15:0] lastcap     = 16'h0000;      // Last value captured
    logic        msk         = 1'b0;          // Mask bit in force
    logic [7:0]  b, c;

    eccp_mode_ctrl #(.TMR_W(16), .DEAD_N(DN)) eccp_mode_ctrl_i (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .timer_i(timer_i), .match_i(match_i), .pwm_raw_i(pwm_raw_i),
        .adc_en_i(adc_en_i), .cap_pin_i(cap_pin_i), .pin_o(pin_o),
        .pin_oe_b_o(pin_oe_b_o), .duty_o(duty_o), .tmr_rst_o(tmr_rst_o),
        .adc_go_o(adc_go_o), .irq_o(irq_o));
    bridge_drv_model bridge_drv_model_i (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .pin_i(pin_o),
        .pin_oe_b_i(pin_oe_b_o), .pad_o(pad), .shoot_o(shoot));

    always #2.5 ref_clk_i = ~ref_clk_i;

    ////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Pad levels for a non-compare mode with steady waveform p
    function automatic pins_t exp_pad(input logic [3:0] m,
                                      input logic [1:0] s, input logic p);
        pins_t v;
        pins_t dr;
        v  = '0;
        dr = '0;
        if (m[3:2] == 2'b11) begin
            case (s)
                2'b00: begin v.a = p; dr = 4'h1; end
                2'b01: begin v.a = 1'b1; v.d = p; dr = 4'hF; end
                2'b10: begin v.a = p; v.b = ~p; dr = 4'h3; end
                default: begin v.b = p; v.c = 1'b1; dr = 4'hF; end
            endcase
            v = v ^ {m[1], m[0], m[1], m[0]};
        end
        return v | ~dr;
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_p(input pins_t got, input pins_t exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t pins %b expected %b", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // One match pulse in compare mode m; pin A should end at e
    task automatic cmp(input logic [3:0] m, input logic e);
        logic [7:0] r;
        wr(ADDR_CTRL, {4'h0, m});
        wr(ADDR_STAT, 8'h01);
        @(posedge ref_clk_i);
        match_i <= 1'b1;
        @(posedge ref_clk_i);
        match_i <= 1'b0;
        #1;
        chk_v(tmr_rst_o, m == 4'hB);
        chk_v(adc_go_o, m == 4'hB && adc_en_i);
        idle(2);
        chk_v(tmr_rst_o, 1'b0);
        chk_p(pad, {3'b111, e});
        chk_v(irq_o, msk);
        rd(ADDR_STAT, r);
        chk_v(r, 8'h01);
    endtask
    // n pin pulses; falls sample t, rises sample ~t
    task automatic cap(input logic [3:0] m, input int n,
                       input logic [15:0] t, input logic f);
        logic [7:0] lo, hi;
        wr(ADDR_CTRL, {4'h0, m});
        wr(ADDR_STAT, 8'h01);
        repeat (n) begin
            timer_i   <= t;
            cap_pin_i <= 1'b0;
            idle(8);
            timer_i   <= ~t;
            cap_pin_i <= 1'b1;
            idle(8);
        end
        if (f) lastcap = (m == 4'h4) ? t : ~t;
        if (m == 4'h0) lastcap = 16'h0000;  // Idle clears the capture
        rd(ADDR_CAP_LO, lo);
        rd(ADDR_CAP_HI, hi);
        chk_v({hi, lo}, lastcap);
        rd(ADDR_STAT, lo);
        chk_v(lo, {7'h0, f});
    endtask

    ////////////////////////////////////////////////////////////////////
    // Hang guard
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        idle(20);
        rst_b_i <= 1'b1;
        chk_p(pin_oe_b_o, 4'hF);
        rd(ADDR_CTRL, b);
        chk_v(b, CTRL_RST);
        rd(ADDR_MASK, b);
        chk_v(b, MASK_RST);
        wr(8'h3C, 8'hFF);
        rd(8'h3C, b);
        chk_v(b, 8'h00);
        // Random waveform in half bridge: legs never both on
        wr(ADDR_CTRL, 8'h8C);
        repeat (300) begin
            @(posedge ref_clk_i);
            rnd = lfsr(rnd);
            pwm_raw_i <= rnd[4];
        end
        idle(DN + 4);
        chk_v(shoot, 1'b0);
        $display("test done: deadband");
        // Every non-compare mode and steering code with both waveform levels
        for (int m = 0; m < 16; m++) begin
            if (m == 2 || m[3:2] == 2'b10) continue;
            for (int s = 0; s < 4; s++) begin
                for (int p = 0; p < 2; p++) begin
                    pwm_raw_i <= p[0];
                    wr(ADDR_CTRL, {s[1:0], 2'b00, m[3:0]});
                    idle(DN + 4);
                    chk_p(pad, exp_pad(m[3:0], s[1:0], p[0]));
                end
            end
        end
        $display("test done: steering");
        // Duty word in PWM and outside it
        repeat (4) begin
            rnd = lfsr(rnd);
            b = rnd[7:0];
            c = rnd[15:8];
            wr(ADDR_DUTY, b);
            wr(ADDR_CTRL, {c[7:4], 4'hC});
            idle(2);
            chk_v(duty_o, {b, c[5:4]});
            wr(ADDR_CTRL, {c[7:4], 4'h8});
            idle(2);
            chk_v(duty_o, 16'h0000);
        end
        $display("test done: duty");
        // Compare modes, unmasked then masked
        msk = 1'b1;
        wr(ADDR_MASK, 8'h01);
        cmp(4'h9, 1'b0);
        cmp(4'h8, 1'b1);
        cmp(4'hA, 1'b1);
        cmp(4'h2, 1'b0);
        cmp(4'h2, 1'b1);
        adc_en_i <= 1'b1;
        cmp(4'hB, 1'b1);
        adc_en_i <= 1'b0;
        msk = 1'b0;
        wr(ADDR_MASK, 8'h00);
        cmp(4'hB, 1'b1);
        $display("test done: compare");
        // Capture edges, prescaling, reserved and off codes
        rnd = lfsr(rnd);
        cap(4'h4, 1, rnd[15:0], 1'b1);
        cap(4'h5, 1, rnd[23:8], 1'b1);
        cap(4'h6, 3, rnd[31:16], 1'b0);
        cap(4'h6, 1, rnd[19:4], 1'b1);
        cap(4'h7, 15, rnd[15:0], 1'b0);
        cap(4'h7, 1, rnd[27:12], 1'b1);
        cap(4'h1, 1, rnd[15:0], 1'b0);
        cap(4'h3, 1, rnd[15:0], 1'b0);
        cap(4'h0, 1, rnd[15:0], 1'b0);
        $display("test done: capture");
        final_report();
    end
endmodule
`default_nettype wire
